/* core/hlef_pkg.sv */
// Package: register map, field layout and carrier types for the link event flags
package hlef_pkg;

   // Register byte addresses
   localparam logic [11:0] HLEF_STATUS_ADDR = 12'h000;
   localparam logic [11:0] HLEF_ENABLE_ADDR = 12'h004;

   // Status field positions
   localparam int HLEF_ST_TX_BEGIN = 6;
   localparam int HLEF_ST_RX_BEGIN = 5;
   localparam int HLEF_ST_TX_END   = 4;
   localparam int HLEF_ST_RX_END   = 3;
   localparam int HLEF_ST_FCS_FAIL = 2;
   localparam int HLEF_ST_ABORT    = 1;
   localparam int HLEF_ST_IDLE     = 0;
   localparam int HLEF_EN_RESERVED = 7;

   // Reset values and masks
   localparam logic [7:0]  HLEF_STATUS_RESET = 8'h00;
   localparam logic [7:0]  HLEF_ENABLE_RESET = 8'h00;
   localparam logic [7:0]  HLEF_ENABLE_MASK  = 8'h7F;
   localparam logic [7:0]  HLEF_EVENT_MASK   = 8'h7F;
   localparam logic [31:0] HLEF_RDATA_ZERO   = 32'h0000_0000;

   // Event strobes from the link controllers
   typedef struct packed {
      logic tx_begin;
      logic rx_begin;
      logic tx_end;
      logic rx_end;
      logic fcs_fail;
      logic abort_seen;
      logic idle_seen;
   } hlef_event_type;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]  status;
      logic [7:0]  enable;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } hlef_state_type;

endpackage

/* core/hlef_top.sv */
// Event flags, enables and interrupt request of the first link controller
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Bit 3 sets when a message ends or the receive buffer fills.
// - Bit 2 sets on frame check mismatch in latest received message.
// - Bit 1 sets when seven consecutive ones arrive on the link channel.
// - Bit 0 sets when the flag octet 7E is seen on the channel.
// - Flags read one if event since last read; read clears; reset zero.
// - Enable bit 6 gates the transmit begin interrupt.
// - Enable bit 5 gates the receive begin interrupt.
// - Enable bit 4 gates the transmit end interrupt.
// - Enable bit 3 gates the receive end interrupt.
// - Enable bits read and write, one enables, reset to zero.
// - Sticky transmit begin flag, cleared on read.
// - Sticky receive begin flag, cleared on read.
// - Sticky transmit end flag, cleared on read.
// - Enable bits 2, 1, 0 gate fcs, abort and idle interrupts.

module hlef_top
   import hlef_pkg::*;
(
   input  wire logic        MCLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   input  wire logic [3:0]  PSTRB_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        TX_BEGIN_I,
   input  wire logic        RX_BEGIN_I,
   input  wire logic        TX_END_I,
   input  wire logic        RX_END_I,
   input  wire logic        FCS_FAIL_I,
   input  wire logic        ABORT_SEEN_I,
   input  wire logic        IDLE_SEEN_I,
   output logic             IRQ_O
);

   hlef_state_type state_reg;
   hlef_state_type state_next;
   hlef_event_type ev;
   // Decode, per-bit next values and per-source request terms
   logic [7:0]     ev_vec;
   logic           take;
   logic           addr_status;
   logic           addr_enable;
   logic           rd_status;
   logic           wr_enable;
   logic [7:0]     status_nxt;
   logic [7:0]     enable_nxt;
   logic [7:0]     enable_set;
   logic [7:0]     enable_clr;
   logic [6:0]     src_irq;

   // Event strobes come from logic on the same clock, so no synchroniser
   assign ev = '{tx_begin:   TX_BEGIN_I,
                 rx_begin:   RX_BEGIN_I,
                 tx_end:     TX_END_I,
                 rx_end:     RX_END_I,
                 fcs_fail:   FCS_FAIL_I,
                 abort_seen: ABORT_SEEN_I,
                 idle_seen:  IDLE_SEEN_I};

   // Map strobes onto status bit positions; the top bit has no event
   assign ev_vec[HLEF_ST_TX_BEGIN] = ev.tx_begin;
   assign ev_vec[HLEF_ST_RX_BEGIN] = ev.rx_begin;
   assign ev_vec[HLEF_ST_TX_END]   = ev.tx_end;
   assign ev_vec[HLEF_ST_RX_END]   = ev.rx_end;
   assign ev_vec[HLEF_ST_FCS_FAIL] = ev.fcs_fail;
   assign ev_vec[HLEF_ST_ABORT]    = ev.abort_seen;
   assign ev_vec[HLEF_ST_IDLE]     = ev.idle_seen;
   assign ev_vec[HLEF_EN_RESERVED] = 1'b0;

   // Access decode; an access is not taken again in the cycle that shows its answer
   assign take        = PSEL_I && PENABLE_I && !state_reg.pready;
   assign addr_status = (PADDR_I == HLEF_STATUS_ADDR);
   assign addr_enable = (PADDR_I == HLEF_ENABLE_ADDR);
   assign rd_status   = take && addr_status && !PWRITE_I;
   assign wr_enable   = take && addr_enable && PWRITE_I && PSTRB_I[0];

   // Enable write split into set and clear terms per bit
   // A lane 0 strobe of zero leaves every enable as it was
   assign enable_set = wr_enable ? (PWDATA_I[7:0] & HLEF_ENABLE_MASK) : HLEF_ENABLE_RESET;
   assign enable_clr = wr_enable ? (~PWDATA_I[7:0] & HLEF_ENABLE_MASK) : HLEF_ENABLE_RESET;

   // Transmit begin flag
   // Software learns early that the sender has picked up its data
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_tx_begin (
      .cur_i (state_reg.status[HLEF_ST_TX_BEGIN]),
      .set_i (ev_vec[HLEF_ST_TX_BEGIN]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_TX_BEGIN])
   );

   // Receive begin flag
   // Marks that a frame has started arriving on the channel
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_rx_begin (
      .cur_i (state_reg.status[HLEF_ST_RX_BEGIN]),
      .set_i (ev_vec[HLEF_ST_RX_BEGIN]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_RX_BEGIN])
   );

   // Transmit end flag
   // Late service here means the sender may run dry
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_tx_end (
      .cur_i (state_reg.status[HLEF_ST_TX_END]),
      .set_i (ev_vec[HLEF_ST_TX_END]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_TX_END])
   );

   // Receive end flag: whole message in, or receive buffer full
   // Both causes share one bit, so software must look at the buffer
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_rx_end (
      .cur_i (state_reg.status[HLEF_ST_RX_END]),
      .set_i (ev_vec[HLEF_ST_RX_END]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_RX_END])
   );

   // Frame check failure flag
   // Covers every message since the last read; older failures are merged
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_fcs_fail (
      .cur_i (state_reg.status[HLEF_ST_FCS_FAIL]),
      .set_i (ev_vec[HLEF_ST_FCS_FAIL]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_FCS_FAIL])
   );

   // Abort flag
   // The run of ones is counted by the receiver, not here
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_abort (
      .cur_i (state_reg.status[HLEF_ST_ABORT]),
      .set_i (ev_vec[HLEF_ST_ABORT]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_ABORT])
   );

   // Flag octet flag
   // The octet match itself lives in the receiver
   hlef_flag_cell #(
      .SET_WINS (1'b1)
   ) u_st_idle (
      .cur_i (state_reg.status[HLEF_ST_IDLE]),
      .set_i (ev_vec[HLEF_ST_IDLE]),
      .clr_i (rd_status),
      .nxt_o (status_nxt[HLEF_ST_IDLE])
   );

   // Transmit begin enable
   // Set and clear never meet here, so priority does not matter
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_tx_begin (
      .cur_i (state_reg.enable[HLEF_ST_TX_BEGIN]),
      .set_i (enable_set[HLEF_ST_TX_BEGIN]),
      .clr_i (enable_clr[HLEF_ST_TX_BEGIN]),
      .nxt_o (enable_nxt[HLEF_ST_TX_BEGIN])
   );

   // Receive begin enable
   // Holds its value between writes
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_rx_begin (
      .cur_i (state_reg.enable[HLEF_ST_RX_BEGIN]),
      .set_i (enable_set[HLEF_ST_RX_BEGIN]),
      .clr_i (enable_clr[HLEF_ST_RX_BEGIN]),
      .nxt_o (enable_nxt[HLEF_ST_RX_BEGIN])
   );

   // Transmit end enable
   // Holds its value between writes
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_tx_end (
      .cur_i (state_reg.enable[HLEF_ST_TX_END]),
      .set_i (enable_set[HLEF_ST_TX_END]),
      .clr_i (enable_clr[HLEF_ST_TX_END]),
      .nxt_o (enable_nxt[HLEF_ST_TX_END])
   );

   // Receive end enable
   // Holds its value between writes
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_rx_end (
      .cur_i (state_reg.enable[HLEF_ST_RX_END]),
      .set_i (enable_set[HLEF_ST_RX_END]),
      .clr_i (enable_clr[HLEF_ST_RX_END]),
      .nxt_o (enable_nxt[HLEF_ST_RX_END])
   );

   // Frame check failure enable
   // Holds its value between writes
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_fcs_fail (
      .cur_i (state_reg.enable[HLEF_ST_FCS_FAIL]),
      .set_i (enable_set[HLEF_ST_FCS_FAIL]),
      .clr_i (enable_clr[HLEF_ST_FCS_FAIL]),
      .nxt_o (enable_nxt[HLEF_ST_FCS_FAIL])
   );

   // Abort enable
   // Holds its value between writes
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_abort (
      .cur_i (state_reg.enable[HLEF_ST_ABORT]),
      .set_i (enable_set[HLEF_ST_ABORT]),
      .clr_i (enable_clr[HLEF_ST_ABORT]),
      .nxt_o (enable_nxt[HLEF_ST_ABORT])
   );

   // Flag octet enable
   // Holds its value between writes
   hlef_flag_cell #(
      .SET_WINS (1'b0)
   ) u_en_idle (
      .cur_i (state_reg.enable[HLEF_ST_IDLE]),
      .set_i (enable_set[HLEF_ST_IDLE]),
      .clr_i (enable_clr[HLEF_ST_IDLE]),
      .nxt_o (enable_nxt[HLEF_ST_IDLE])
   );

   // Top bit of both registers has no storage and reads zero
   assign status_nxt[HLEF_EN_RESERVED] = 1'b0;
   assign enable_nxt[HLEF_EN_RESERVED] = 1'b0;

   // One request term per source, taken from the next flags,
   // so flag and request change on the same edge
   assign src_irq[HLEF_ST_TX_BEGIN] = status_nxt[HLEF_ST_TX_BEGIN] & enable_nxt[HLEF_ST_TX_BEGIN];
   assign src_irq[HLEF_ST_RX_BEGIN] = status_nxt[HLEF_ST_RX_BEGIN] & enable_nxt[HLEF_ST_RX_BEGIN];
   assign src_irq[HLEF_ST_TX_END]   = status_nxt[HLEF_ST_TX_END] & enable_nxt[HLEF_ST_TX_END];
   assign src_irq[HLEF_ST_RX_END]   = status_nxt[HLEF_ST_RX_END] & enable_nxt[HLEF_ST_RX_END];
   assign src_irq[HLEF_ST_FCS_FAIL] = status_nxt[HLEF_ST_FCS_FAIL] & enable_nxt[HLEF_ST_FCS_FAIL];
   assign src_irq[HLEF_ST_ABORT]    = status_nxt[HLEF_ST_ABORT] & enable_nxt[HLEF_ST_ABORT];
   assign src_irq[HLEF_ST_IDLE]     = status_nxt[HLEF_ST_IDLE] & enable_nxt[HLEF_ST_IDLE];

   // Next state: bus answer, flags, enables and request in one copy
   always_comb begin
      state_next = state_reg;

      // Answer every access one cycle after the take edge
      state_next.pready  = take;
      state_next.pslverr = take && !addr_status && !addr_enable; // Unmapped address
      state_next.prdata  = HLEF_RDATA_ZERO;

      // Read data is the value before the read clears it
      if (take && !PWRITE_I && addr_status) begin
         state_next.prdata = {24'h000000, state_reg.status};
      end else if (take && !PWRITE_I && addr_enable) begin
         state_next.prdata = {24'h000000, state_reg.enable};
      end

      // Flags and enables from the per-bit cells
      state_next.status = status_nxt & HLEF_EVENT_MASK;
      state_next.enable = enable_nxt & HLEF_ENABLE_MASK;

      // Request follows the registered flags, not the raw strobes
      state_next.irq = |src_irq;
   end

   // State register
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         state_reg <= '{status:  HLEF_STATUS_RESET,
                        enable:  HLEF_ENABLE_RESET,
                        prdata:  HLEF_RDATA_ZERO,
                        pready:  1'b0,
                        pslverr: 1'b0,
                        irq:     1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign PRDATA_O  = state_reg.prdata;
   assign PREADY_O  = state_reg.pready;
   assign PSLVERR_O = state_reg.pslverr;
   assign IRQ_O     = state_reg.irq;

endmodule

// One sticky or writable bit: next value from hold, set and clear
// Shared by flags and enables so the priority choice sits in one place
module hlef_flag_cell
   import hlef_pkg::*;
#(
   parameter bit SET_WINS = 1'b1
) (
   input  wire logic cur_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      nxt_o
);

   // Set beats clear on flags, so an event on the read edge is kept
   always_comb begin
      if (SET_WINS) begin
         nxt_o = set_i | (cur_i & !clr_i);
      end else begin
         nxt_o = !clr_i & (set_i | cur_i);
      end
   end

endmodule

/* test/hdlc_link_event_flags_tb_top.sv */
// Testbench for the link event flags
`timescale 1ns/10ps
module hdlc_link_event_flags_tb_top;
   import hlef_pkg::*;
   logic MCLK_I = 0, RESET_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, PREADY_O, PSLVERR_O, IRQ_O;
   logic [11:0] PADDR_I = 0;
   logic [31:0] PWDATA_I = 0, PRDATA_O, rd;
   logic [3:0]  PSTRB_I = 4'hF;
   logic        err;
   logic TX_BEGIN_I, RX_BEGIN_I, TX_END_I, RX_END_I, FCS_FAIL_I, ABORT_SEEN_I, IDLE_SEEN_I;
   hlef_event_type ev;
   int failures = 0, total_checks = 0;
   assign {TX_BEGIN_I, RX_BEGIN_I, TX_END_I, RX_END_I, FCS_FAIL_I, ABORT_SEEN_I, IDLE_SEEN_I} = ev;
   hlef_top u_dut (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
                   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
                   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TX_BEGIN_I(TX_BEGIN_I),
                   .RX_BEGIN_I(RX_BEGIN_I), .TX_END_I(TX_END_I), .RX_END_I(RX_END_I), .FCS_FAIL_I(FCS_FAIL_I),
                   .ABORT_SEEN_I(ABORT_SEEN_I), .IDLE_SEEN_I(IDLE_SEEN_I), .IRQ_O(IRQ_O));
   hlef_link_src u_src (.clk_i(MCLK_I), .ev_o(ev));
   always #5 MCLK_I = ~MCLK_I;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bounded wait, so a dead slave cannot hang us
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge MCLK_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge MCLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge MCLK_I); while (PREADY_O !== 1'b1 && ++n < 20);
      rd = PRDATA_O;
      err = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      if (n >= 20) failures++;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic t_flags();
      rdchk(HLEF_ENABLE_ADDR, 32'h0);
      apb(1'b1, HLEF_STATUS_ADDR, 32'hFF);
      for (int i = 0; i < 7; i++) begin
         u_src.pulse(7'h01 << i);
         rdchk(HLEF_STATUS_ADDR, 32'h1 << i);
         rdchk(HLEF_STATUS_ADDR, 32'h0);
      end
      rdchk(12'h008, 32'h0);
      chk(err, 1'b1);
      $display("test flags done");
   endtask
   // Each enabled source raises the request, a read drops it
   task automatic t_irq();
      apb(1'b1, HLEF_ENABLE_ADDR, 32'hFF);
      rdchk(HLEF_ENABLE_ADDR, 32'h7F);
      for (int i = 0; i < 7; i++) begin
         u_src.pulse(7'h01 << i);
         @(posedge MCLK_I);
         chk(IRQ_O, 1'b1);
         rdchk(HLEF_STATUS_ADDR, 32'h1 << i);
         chk(IRQ_O, 1'b0);
      end
      apb(1'b1, HLEF_ENABLE_ADDR, 32'h0);
      u_src.pulse(7'h7F);
      @(posedge MCLK_I);
      chk(IRQ_O, 1'b0);
      rdchk(HLEF_STATUS_ADDR, 32'h7F);
      $display("test irq done");
   endtask
   // Joint events, an event on the read edge, and a write with lane 0 off
   task automatic t_misc();
      u_src.pulse(7'h09);
      rdchk(HLEF_STATUS_ADDR, 32'h9);
      fork
         rdchk(HLEF_STATUS_ADDR, 32'h0);
         begin
            repeat (2) @(posedge MCLK_I);
            u_src.pulse(7'h08);
         end
      join
      rdchk(HLEF_STATUS_ADDR, 32'h8);
      PSTRB_I <= 4'h0;
      apb(1'b1, HLEF_ENABLE_ADDR, 32'h7F);
      PSTRB_I <= 4'hF;
      rdchk(HLEF_ENABLE_ADDR, 32'h0);
      $display("test misc done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge MCLK_I);
      RESET_N_I <= 1'b1;
      t_flags();
      t_irq();
      t_misc();
      test_done();
   end
   // Watchdog far beyond the roughly 180 cycles needed
   initial begin
      #100000;
      failures++;
      test_done();
   end
endmodule
bind hlef_top hlef_props u_props (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O));

/* test/hlef_link_src.sv */
// Event source in place of the link controllers
`timescale 1ns/10ps
module hlef_link_src
   import hlef_pkg::*;
(
   input  wire logic     clk_i,
   output hlef_event_type ev_o
);
   // Quiet until asked; one-cycle strobes only
   initial ev_o = '0;
   task automatic pulse(input logic [6:0] m);
      ev_o <= m;
      @(posedge clk_i);
      ev_o <= '0;
   endtask
endmodule

/* test/hlef_props.sv */
// Checker for bus answer and interrupt
`timescale 1ns/10ps
module hlef_props (
   input wire logic        MCLK_I,
   input wire logic        RESET_N_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        IRQ_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RESET_N_I);
   a_one_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O) else $error("late");
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("long");
   a_ready_cause: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I)) else $error("stray");
   a_err_map: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I > 12'h004 || PADDR_I[1:0] != 2'h0)) else $error("err");
   a_err_alone: assert property (PSLVERR_O |-> PREADY_O) else $error("err");
   a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("data");
   a_rdata_high: assert property (PREADY_O |-> PRDATA_O[31:7] == 25'h0) else $error("high");
   a_irq_reset: assert property ($rose(RESET_N_I) |-> !IRQ_O) else $error("irq");
   // Main scenarios reached
   cover property (PSLVERR_O);
   cover property (IRQ_O);
   cover property (PREADY_O && PRDATA_O != 32'h0);
endmodule
